//--- pkg/odh_pkg.sv
// shared constants for the octal dac parallel-port host controller
package odh_pkg;
  localparam int unsigned CODE_W = 13;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // least pin times in ns
  localparam int unsigned T_CS_LOW_NS = 50;
  localparam int unsigned T_WR_LOW_NS = 50;
  localparam int unsigned T_LD_LOW_NS = 50;
  localparam int unsigned T_DATA_SETUP_NS = 50;
  localparam int unsigned T_ADDR_SETUP_NS = 15;
  localparam int unsigned T_CLR_LOW_NS = 50;
  // least times round up to whole cycles
  localparam int unsigned WR_LOW_CYC =
    (T_WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LD_LOW_CYC =
    (T_LD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC =
    (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CLR_LOW_CYC =
    (T_CLR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  localparam logic [CODE_W-1:0] CODE_RESET = 13'h0000;
  localparam logic [CODE_W-1:0] TWOS_OFFSET = 13'h1000;
  typedef enum logic [2:0]
  {
    ODH_IDLE = 3'b000,
    ODH_SETUP = 3'b001,
    ODH_STROBE = 3'b010,
    ODH_RELEASE = 3'b011,
    ODH_LOAD = 3'b100
  } odh_state_t;
endpackage

//--- logic/odh_cycle_timer.sv
// down-counter that times a pin phase in whole clock cycles
`timescale 1ns/1ps
module odh_cycle_timer
  import odh_pkg::*;
(
  // clock
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // control
  input wire logic start_in,
  input wire logic [CNT_W-1:0] count_in,
  // status
  output logic done_out
);
  logic [CNT_W-1:0] count_reg;

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      count_reg <= '0;
    end
    else if (clk_en_in)
    begin
      if (start_in)
        count_reg <= count_in;
      else if (count_reg != '0)
        count_reg <= count_reg - 1'b1;
    end
  end

  // no path from start_in: the sequencer feeds done back into start
  assign done_out = (count_reg == '0);
endmodule // odh_cycle_timer

//--- logic/odh_host.sv
// host controller driving the octal dac parallel write and load pins
// Operation
// RQ1: device copies input latches while load low
// RQ2: pulse load low to update all channels
// RQ3: input latch transparent while select, strobe low
// RQ4: strobe rising edge captures code into channel
// RQ5: select qualifies, strobe pulses, memory-write style
// RQ6: thirteen-bit offset-binary code on the bus
// RQ7: clear low forces outputs to sense ground
// RQ8: clear never alters stored codes
// RQ9: clear released restores held code output
// RQ10: select low needed for any write
// RQ11: three select bits choose channel binary
// RQ12: select, strobe, load low make channel transparent
// RQ13: channel select stable while strobe low
// RQ14: device outputs are combinational, no clock
`timescale 1ns/1ps
module odh_host
  import odh_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  // user request
  input wire logic write_req_in,
  input wire logic [SEL_W-1:0] write_chan_in,
  input wire logic [CODE_W-1:0] write_code_in,
  input wire logic code_is_twos_in,
  input wire logic load_after_in,
  input wire logic load_req_in,
  input wire logic clear_req_in,
  // user status
  output logic busy_out,
  output logic done_out,
  // device pins
  output logic chip_sel_n_out,
  output logic write_strobe_n_out,
  output logic load_strobe_n_out,
  output logic clear_n_out,
  output logic channel_sel_msb_out,
  output logic channel_sel_mid_out,
  output logic channel_sel_lsb_out,
  output logic [CODE_W-1:0] code_bus_out
);
  odh_state_t state_reg;
  logic [SEL_W-1:0] chan_reg;
  logic [CODE_W-1:0] code_reg;
  logic load_after_reg;
  logic timer_start;
  logic [CNT_W-1:0] timer_count;
  logic timer_done;
  logic [CNT_W-1:0] clr_cnt_reg;

  odh_cycle_timer u_timer
  (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .clk_en_in(clk_en_in),
    .start_in(timer_start),
    .count_in(timer_count),
    .done_out(timer_done)
  );

  // phase sequencer
  always_comb
  begin
    timer_start = 1'b0;
    timer_count = '0;
    unique case (state_reg)
      ODH_IDLE:
      begin
        if (write_req_in)
        begin
          timer_start = 1'b1;
          timer_count = CNT_W'(SETUP_CYC);
        end
        else if (load_req_in)
        begin
          timer_start = 1'b1;
          timer_count = CNT_W'(LD_LOW_CYC);
        end
      end
      ODH_SETUP:
      begin
        if (timer_done)
        begin
          timer_start = 1'b1;
          timer_count = CNT_W'(WR_LOW_CYC);
        end
      end
      ODH_STROBE, ODH_RELEASE:
      begin
        if (timer_done && state_reg == ODH_RELEASE && load_after_reg)
        begin
          timer_start = 1'b1;
          timer_count = CNT_W'(LD_LOW_CYC);
        end
      end
      ODH_LOAD:
      begin
      end
      default:
      begin
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      state_reg <= ODH_IDLE;
      chan_reg <= '0;
      code_reg <= CODE_RESET;
      load_after_reg <= 1'b0;
    end
    else if (clk_en_in)
    begin
      unique case (state_reg)
        ODH_IDLE:
        begin
          if (write_req_in)
          begin
            chan_reg <= write_chan_in; // RQ11
            // two's complement becomes offset binary by adding half scale
            code_reg <= code_is_twos_in ?
              CODE_W'(write_code_in + TWOS_OFFSET) : write_code_in; // RQ6
            load_after_reg <= load_after_in;
            state_reg <= ODH_SETUP;
          end
          else if (load_req_in)
            state_reg <= ODH_LOAD; // RQ2
        end
        ODH_SETUP:
          if (timer_done)
            state_reg <= ODH_STROBE; // RQ3
        ODH_STROBE:
          if (timer_done)
            state_reg <= ODH_RELEASE; // RQ4
        ODH_RELEASE:
          state_reg <= load_after_reg ? ODH_LOAD : ODH_IDLE;
        ODH_LOAD:
          if (timer_done)
            state_reg <= ODH_IDLE; // RQ1
        default:
          state_reg <= ODH_IDLE;
      endcase
    end
  end

  // pin drive; select and channel bits held through the whole strobe
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      chip_sel_n_out <= 1'b1;
      write_strobe_n_out <= 1'b1;
      load_strobe_n_out <= 1'b1;
      channel_sel_msb_out <= 1'b0;
      channel_sel_mid_out <= 1'b0;
      channel_sel_lsb_out <= 1'b0;
      code_bus_out <= CODE_RESET;
    end
    else if (clk_en_in)
    begin
      // select wraps the strobe so it is low whenever strobe is low
      chip_sel_n_out <= !(state_reg == ODH_SETUP ||
        state_reg == ODH_STROBE); // RQ10 RQ5
      write_strobe_n_out <= !(state_reg == ODH_STROBE); // RQ5 RQ4
      // load never overlaps strobe, avoiding direct-drive glitches
      load_strobe_n_out <= !(state_reg == ODH_LOAD); // RQ2 RQ12
      channel_sel_msb_out <= chan_reg[2]; // RQ13
      channel_sel_mid_out <= chan_reg[1];
      channel_sel_lsb_out <= chan_reg[0];
      code_bus_out <= code_reg; // RQ6
    end
  end

  // clear held while requested and for its minimum after the request drops, then released
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      clear_n_out <= 1'b1;
      clr_cnt_reg <= '0;
    end
    else if (clk_en_in)
    begin
      if (clear_req_in)
      begin
        clear_n_out <= 1'b0; // RQ7 RQ8
        clr_cnt_reg <= CNT_W'(CLR_LOW_CYC);
      end
      else if (clr_cnt_reg != '0)
        clr_cnt_reg <= clr_cnt_reg - 1'b1;
      else
        clear_n_out <= 1'b1; // RQ9
    end
  end

  // status; the device answers combinationally so no readback exists
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      busy_out <= (state_reg != ODH_IDLE) || write_req_in || load_req_in;
      done_out <= (state_reg == ODH_LOAD && timer_done) ||
        (state_reg == ODH_RELEASE && !load_after_reg); // RQ14
    end
  end
endmodule // odh_host

//--- bench/odh_host_monitor.sv
// pin rule checker for the dac host controller
`timescale 1ns/1ps
module odh_host_monitor
  import odh_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic chip_sel_n_out,
  input wire logic write_strobe_n_out,
  input wire logic load_strobe_n_out,
  input wire logic clear_n_out,
  input wire logic channel_sel_msb_out,
  input wire logic channel_sel_mid_out,
  input wire logic channel_sel_lsb_out,
  input wire logic [CODE_W-1:0] code_bus_out,
  input wire logic done_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  AST_WR_NEEDS_CS: assert property (
    !write_strobe_n_out |-> !chip_sel_n_out) else $error("strobe w/o cs");
  AST_WR_WIDTH: assert property (
    $fell(write_strobe_n_out) |-> !write_strobe_n_out[*5])
    else $error("strobe short");
  AST_LD_WIDTH: assert property (
    $fell(load_strobe_n_out) |-> !load_strobe_n_out[*5])
    else $error("load short");
  AST_BUS_STABLE: assert property (
    !write_strobe_n_out ##1 !write_strobe_n_out |-> $stable(code_bus_out))
    else $error("bus moved");
  AST_NO_LD_IN_WR: assert property (
    !write_strobe_n_out |-> load_strobe_n_out) else $error("load in write");
  AST_SEL_STABLE: assert property (
    (!chip_sel_n_out && !write_strobe_n_out) ##1
    (!chip_sel_n_out && !write_strobe_n_out) |->
    $stable({channel_sel_msb_out, channel_sel_mid_out, channel_sel_lsb_out}))
    else $error("select moved");
  AST_CLR_WIDTH: assert property (
    $fell(clear_n_out) |-> !clear_n_out[*5])
    else $error("clear short");
  C_WR: cover property ($rose(write_strobe_n_out));
  C_LD: cover property ($rose(load_strobe_n_out));
  C_DONE: cover property (done_out);
endmodule // odh_host_monitor
bind odh_host odh_host_monitor u_mon (.clk_sys_in(clk_sys_in),
  .reset_in(reset_in), .chip_sel_n_out(chip_sel_n_out),
  .write_strobe_n_out(write_strobe_n_out),
  .load_strobe_n_out(load_strobe_n_out), .clear_n_out(clear_n_out),
  .channel_sel_msb_out(channel_sel_msb_out),
  .channel_sel_mid_out(channel_sel_mid_out),
  .channel_sel_lsb_out(channel_sel_lsb_out),
  .code_bus_out(code_bus_out), .done_out(done_out));

//--- bench/odh_dac_model.sv
// clockless model of the octal dac latches and outputs
`timescale 1ns/1ps
module odh_dac_model
  import odh_pkg::*;
(
  // pins
  input wire logic chip_sel_n_in,
  input wire logic write_strobe_n_in,
  input wire logic load_strobe_n_in,
  input wire logic clear_n_in,
  input wire logic [SEL_W-1:0] sel_in,
  input wire logic [CODE_W-1:0] code_bus_in,
  // per channel state, zero stands for sense ground
  output logic [CODE_W-1:0] dac_out [8],
  output logic [CODE_W-1:0] level_out [8]
);
  logic [CODE_W-1:0] in_reg [8];
  always @(*)
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (!chip_sel_n_in && !write_strobe_n_in && sel_in == i)
        in_reg[i] = code_bus_in;
      if (!load_strobe_n_in)
        dac_out[i] = in_reg[i];
      // clear only masks outputs, latches untouched
      level_out[i] = clear_n_in ? dac_out[i] : '0;
    end
  end
endmodule // odh_dac_model

//--- bench/odh_host_tb.sv
// self-checking bench for the dac host controller
`timescale 1ns/1ps
module odh_host_tb;
  import odh_pkg::*;
  typedef struct {logic [2:0] ch; logic [12:0] cd; logic tw;
    logic [12:0] ex;} odh_row_t;
  logic clk_sys_in = 0, reset_in = 1, wr = 0, tw = 0, la = 0, ld = 0, cl = 0;
  logic en = 1;
  logic [2:0] ch = 0;
  logic [12:0] cd = 0;
  logic busy, done, cs_n, wr_n, ld_n, clr_n, s2, s1, s0;
  logic [12:0] bus;
  logic [12:0] dac [8];
  logic [12:0] lvl [8];
  int fails = 0, check_count = 0;
  odh_row_t rows [8] = '{'{0, 13'h0001, 0, 13'h0001},
    '{1, 13'h1fff, 0, 13'h1fff}, '{2, 13'h1fff, 1, 13'h0fff},
    '{3, 13'h0000, 1, 13'h1000}, '{4, 13'h0800, 1, 13'h1800},
    '{5, 13'h0aaa, 0, 13'h0aaa}, '{6, 13'h1555, 0, 13'h1555},
    '{7, 13'h0f0f, 0, 13'h0f0f}};
  initial forever #5 clk_sys_in = ~clk_sys_in;
  odh_host u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .clk_en_in(en), .write_req_in(wr), .write_chan_in(ch),
    .write_code_in(cd), .code_is_twos_in(tw), .load_after_in(la),
    .load_req_in(ld), .clear_req_in(cl), .busy_out(busy), .done_out(done),
    .chip_sel_n_out(cs_n), .write_strobe_n_out(wr_n),
    .load_strobe_n_out(ld_n), .clear_n_out(clr_n),
    .channel_sel_msb_out(s2), .channel_sel_mid_out(s1),
    .channel_sel_lsb_out(s0), .code_bus_out(bus));
  odh_dac_model u_dac (.chip_sel_n_in(cs_n), .write_strobe_n_in(wr_n),
    .load_strobe_n_in(ld_n), .clear_n_in(clr_n), .sel_in({s2, s1, s0}),
    .code_bus_in(bus), .dac_out(dac), .level_out(lvl));
  task chk(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task stop_test;
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one request cycle, then wait for the done pulse
  task req(input logic w, input logic l);
    @(posedge clk_sys_in) #1;
    wr = w;
    ld = l;
    @(posedge clk_sys_in) #1;
    wr = 0;
    ld = 0;
    chk(busy, 1'b1);
    for (int n = 0; n < 60 && done !== 1'b1; n++)
      @(posedge clk_sys_in) #1;
    chk(done, 1'b1);
  endtask
  initial
  begin
    #100000;
    fails++;
    stop_test;
  end
  initial
  begin
    repeat (8) @(posedge clk_sys_in);
    #1 reset_in = 0;
    chk({cs_n, wr_n, ld_n, clr_n}, 4'hf);
    la = 1;
    foreach (rows[i])
    begin
      {ch, cd, tw} = {rows[i].ch, rows[i].cd, rows[i].tw};
      req(1, 0);
      chk(lvl[ch], rows[i].ex);
    end
    foreach (rows[i])
      chk(lvl[rows[i].ch], rows[i].ex);
    {la, tw, ch, cd} = {1'b0, 1'b0, 3'h2, 13'h0123};
    req(1, 0);
    chk(lvl[2], 13'h0fff);
    req(0, 1);
    chk(lvl[2], 13'h0123);
    cl = 1;
    repeat (3) @(posedge clk_sys_in);
    #1 chk(lvl[7], 13'h0000);
    chk(dac[7], 13'h0f0f);
    cl = 0;
    repeat (12) @(posedge clk_sys_in);
    #1 chk(lvl[7], 13'h0f0f);
    // clock enable low: a load request must not be taken
    en = 0;
    ld = 1;
    @(posedge clk_sys_in) #1;
    ld = 0;
    repeat (8) @(posedge clk_sys_in);
    #1 chk({busy, ld_n}, 2'b01);
    // reset in mid-strobe, then the next write must still work
    en = 1;
    {ch, cd} = {3'h5, 13'h0abc};
    wr = 1;
    @(posedge clk_sys_in) #1;
    wr = 0;
    repeat (5) @(posedge clk_sys_in);
    #1 reset_in = 1;
    repeat (2) @(posedge clk_sys_in);
    #1 reset_in = 0;
    chk({busy, done, cs_n, wr_n, ld_n, clr_n}, 6'h0f);
    {la, ch, cd} = {1'b1, 3'h0, 13'h0123};
    req(1, 0);
    chk(lvl[0], 13'h0123);
    stop_test;
  end
endmodule // odh_host_tb
